// ---- hdl/sdbcs_map.svh ----
// sdbcs_map.svh: timing figures, cycle counts, read latency, burst length and auto-precharge bit
// assumes a 100 MHz system clock
`ifndef SDBCS_MAP_SVH
`define SDBCS_MAP_SVH
`define SDBCS_CLK_MHZ 100
`define SDBCS_PRECHARGE_TIME_NS 20
`define SDBCS_ACT_TO_ACCESS_TIME_NS 20
`define SDBCS_REFRESH_CYCLE_TIME_NS 70
`define SDBCS_MODE_LOAD_TIME_NS 20
`define SDBCS_SELF_REFRESH_EXIT_TIME_NS 80
`define SDBCS_NS_TO_CYC(ns) ((((ns) * `SDBCS_CLK_MHZ) + 999) / 1000)
`define SDBCS_PRECHARGE_CYC `SDBCS_NS_TO_CYC(`SDBCS_PRECHARGE_TIME_NS)
`define SDBCS_ACT_TO_ACCESS_CYC `SDBCS_NS_TO_CYC(`SDBCS_ACT_TO_ACCESS_TIME_NS)
`define SDBCS_REFRESH_CYC `SDBCS_NS_TO_CYC(`SDBCS_REFRESH_CYCLE_TIME_NS)
`define SDBCS_MODE_LOAD_CYC `SDBCS_NS_TO_CYC(`SDBCS_MODE_LOAD_TIME_NS)
`define SDBCS_SELF_REFRESH_EXIT_CYC `SDBCS_NS_TO_CYC(`SDBCS_SELF_REFRESH_EXIT_TIME_NS)
`define SDBCS_READ_LATENCY 3
`define SDBCS_BURST_LEN 4
`define SDBCS_AP_BIT 10
`endif

// ---- hdl/sdbcs_pkg.sv ----
// sdbcs_pkg: command, state and bus types of the bank command logic
// assumes nothing beyond the map header
package sdbcs_pkg;
   typedef enum logic [3:0] {
      SDBCS_CMD_INHIBIT = 4'h0,
      SDBCS_CMD_NOP = 4'h1,
      SDBCS_CMD_ACTIVE = 4'h2,
      SDBCS_CMD_READ = 4'h3,
      SDBCS_CMD_WRITE = 4'h4,
      SDBCS_CMD_PRECHARGE = 4'h5,
      SDBCS_CMD_TERMINATE = 4'h6,
      SDBCS_CMD_REFRESH = 4'h7,
      SDBCS_CMD_MODE_LOAD = 4'h8
   } sdbcs_cmd_t;
   typedef enum logic [2:0] {
      SDBCS_B_IDLE = 3'h0,
      SDBCS_B_ACTIVATING = 3'h1,
      SDBCS_B_ROW_ACTIVE = 3'h2,
      SDBCS_B_READ = 3'h3,
      SDBCS_B_WRITE = 3'h4,
      SDBCS_B_READ_AP = 3'h5,
      SDBCS_B_WRITE_AP = 3'h6,
      SDBCS_B_PRECHARGING = 3'h7
   } sdbcs_bank_state_t;
   typedef enum logic [1:0] {
      SDBCS_D_BANKS = 2'h0,
      SDBCS_D_REFRESH = 2'h1,
      SDBCS_D_MODE_LOAD = 2'h2,
      SDBCS_D_PRE_ALL = 2'h3
   } sdbcs_dev_state_t;
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [1:0] bank_select;
      logic [11:0] addr;
   } sdbcs_pins_t;
   typedef struct packed {
      sdbcs_cmd_t cmd;
      logic [1:0] bank;
      logic auto_pre;
      logic all_banks;
   } sdbcs_dec_t;
endpackage

// ---- hdl/sdbcs_decode.sv ----
// sdbcs_decode: turns the four command pins into a command code
// assumes pins already registered to i_clk_sys by the caller
`timescale 1ns/1ps
`include "sdbcs_map.svh"
module sdbcs_decode
   import sdbcs_pkg::*;
(
   // pins
   input wire sdbcs_pins_t i_pins,
   // decoded
   output sdbcs_dec_t o_dec
);
   always_comb begin
      o_dec.bank = i_pins.bank_select;
      o_dec.auto_pre = i_pins.addr[`SDBCS_AP_BIT];
      o_dec.all_banks = i_pins.addr[`SDBCS_AP_BIT];
      if (i_pins.cs_n) begin
         o_dec.cmd = SDBCS_CMD_INHIBIT;
      end else begin
         unique case ({i_pins.ras_n, i_pins.cas_n, i_pins.we_n})
            3'b111: o_dec.cmd = SDBCS_CMD_NOP;
            3'b011: o_dec.cmd = SDBCS_CMD_ACTIVE;
            3'b101: o_dec.cmd = SDBCS_CMD_READ;
            3'b100: o_dec.cmd = SDBCS_CMD_WRITE;
            3'b010: o_dec.cmd = SDBCS_CMD_PRECHARGE;
            3'b110: o_dec.cmd = SDBCS_CMD_TERMINATE;
            3'b001: o_dec.cmd = SDBCS_CMD_REFRESH;
            3'b000: o_dec.cmd = SDBCS_CMD_MODE_LOAD;
         endcase
      end
   end
endmodule // sdbcs_decode

// ---- hdl/sdbcs_bank.sv ----
// sdbcs_bank: state of one bank with its timer
// assumes the top qualifies commands with clock enable and device state
`timescale 1ns/1ps
`include "sdbcs_map.svh"
module sdbcs_bank
   import sdbcs_pkg::*;
#(
   parameter int TRP_CYC = `SDBCS_PRECHARGE_CYC,
   parameter int ACTIVATE_TO_ACCESS_TIME_CYC = `SDBCS_ACT_TO_ACCESS_CYC,
   parameter int BURST_LEN = `SDBCS_BURST_LEN
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // commands for this bank
   input wire logic i_act,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic i_auto_pre,
   input wire logic i_pre,
   input wire logic i_stop,
   input wire logic i_interrupt,
   input wire logic i_force_idle,
   // state
   output sdbcs_bank_state_t o_state
);
   localparam int CW = 8;
   sdbcs_bank_state_t state_ff;
   logic [CW-1:0] cnt_ff;
   logic ap_pend_ff;
   wire timer_done = (cnt_ff == '0);
   wire burst_busy = (state_ff == SDBCS_B_READ) || (state_ff == SDBCS_B_WRITE);

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn || i_force_idle) begin
         state_ff <= SDBCS_B_IDLE;
         cnt_ff <= '0;
         ap_pend_ff <= 1'b0;
      end else begin
         unique case (state_ff)
            SDBCS_B_IDLE: begin
               // precharge to an idle bank changes nothing
               if (i_act) begin
                  state_ff <= SDBCS_B_ACTIVATING;
                  cnt_ff <= CW'(ACTIVATE_TO_ACCESS_TIME_CYC - 1);
               end
            end
            SDBCS_B_ACTIVATING: begin
               if (timer_done) state_ff <= SDBCS_B_ROW_ACTIVE;
               else cnt_ff <= cnt_ff - 1'b1;
            end
            SDBCS_B_READ_AP, SDBCS_B_WRITE_AP: begin
               // burst counts down, then the precharge time; interrupted burst precharges now
               if (i_interrupt && ap_pend_ff) begin
                  ap_pend_ff <= 1'b0;
                  cnt_ff <= CW'(TRP_CYC - 1);
               end else if (!timer_done) begin
                  cnt_ff <= cnt_ff - 1'b1;
               end else if (ap_pend_ff) begin
                  ap_pend_ff <= 1'b0;
                  cnt_ff <= CW'(TRP_CYC - 1);
               end else begin
                  state_ff <= SDBCS_B_IDLE;
               end
            end
            SDBCS_B_PRECHARGING: begin
               if (timer_done) state_ff <= SDBCS_B_IDLE;
               else cnt_ff <= cnt_ff - 1'b1;
            end
            default: begin
               // row active, read or write
               if (i_pre) begin
                  state_ff <= SDBCS_B_PRECHARGING;
                  cnt_ff <= CW'(TRP_CYC - 1);
               end else if (i_rd || i_wr) begin
                  if (i_auto_pre) begin
                     state_ff <= i_rd ? SDBCS_B_READ_AP : SDBCS_B_WRITE_AP;
                     ap_pend_ff <= 1'b1;
                  end else begin
                     state_ff <= i_rd ? SDBCS_B_READ : SDBCS_B_WRITE;
                  end
                  cnt_ff <= CW'(BURST_LEN - 1);
               end else if (burst_busy && (i_stop || i_interrupt || timer_done)) begin
                  state_ff <= SDBCS_B_ROW_ACTIVE;
               end else if (burst_busy) begin
                  cnt_ff <= cnt_ff - 1'b1;
               end
            end
         endcase
      end
   end

   assign o_state = state_ff;
endmodule // sdbcs_bank

// ---- hdl/sdbcs_top.sv ----
// sdbcs_top: command decoder and bank state tracking of a four-bank sdram
// assumes the controller drives pins synchronous to i_clk_sys
`timescale 1ns/1ps
`include "sdbcs_map.svh"
module sdbcs_top
   import sdbcs_pkg::*;
#(
   parameter int NUM_BANKS = 4,
   parameter int TRP_CYC = `SDBCS_PRECHARGE_CYC,
   parameter int ACTIVATE_TO_ACCESS_TIME_CYC = `SDBCS_ACT_TO_ACCESS_CYC,
   parameter int REFRESH_CYCLE_TIME_CYC = `SDBCS_REFRESH_CYC,
   parameter int MODE_LOAD_TIME_CYC = `SDBCS_MODE_LOAD_CYC,
   parameter int SELF_REFRESH_EXIT_TIME_CYC = `SDBCS_SELF_REFRESH_EXIT_CYC,
   parameter int READ_LATENCY = `SDBCS_READ_LATENCY,
   parameter int BURST_LEN = `SDBCS_BURST_LEN
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // command pins
   input wire sdbcs_pins_t i_pins,
   input wire logic i_cke,
   input wire logic i_self_refresh_exit,
   // state view
   output sdbcs_bank_state_t [NUM_BANKS-1:0] o_bank_state,
   output sdbcs_dev_state_t o_dev_state,
   output logic o_all_idle,
   output logic o_cmd_accepted,
   output logic o_cmd_illegal,
   output logic [1:0] o_data_bank,
   output logic o_data_read,
   output logic o_data_valid
);
   localparam int CW = 8;
   localparam int BW = 2 * READ_LATENCY;

   sdbcs_dec_t dec;
   sdbcs_bank_state_t [NUM_BANKS-1:0] bst;
   sdbcs_dev_state_t dev_ff;
   logic [CW-1:0] dev_cnt_ff;
   logic [CW-1:0] xsr_cnt_ff;
   logic cke_prev_ff;
   logic [1:0] last_bank_ff;
   logic last_valid_ff;
   logic [NUM_BANKS-1:0] b_act, b_rd, b_wr, b_pre, b_stop, b_intr;
   logic legal;
   logic go;
   logic [READ_LATENCY-1:0] rl_vld_ff;
   logic [READ_LATENCY-1:0][1:0] rl_bank_ff;
   logic [1:0] data_bank_ff;
   logic data_read_ff;
   logic data_valid_ff;
   logic [CW-1:0] data_cnt_ff;

   sdbcs_decode u_decode (
      .i_pins(i_pins),
      .o_dec(dec)
   );

   // commands count only with clock enable held and exit time over
   wire cmd_window = cke_prev_ff && i_cke && (xsr_cnt_ff == '0);
   wire dev_free = (dev_ff == SDBCS_D_BANKS);
   sdbcs_bank_state_t tgt;
   assign tgt = bst[dec.bank];

   always_comb begin
      o_all_idle = 1'b1;
      for (int i = 0; i < NUM_BANKS; i++) begin
         if (bst[i] != SDBCS_B_IDLE) o_all_idle = 1'b0;
      end
   end

   // legality of the decoded command against its bank and the device
   always_comb begin
      legal = 1'b0;
      unique case (dec.cmd)
         SDBCS_CMD_INHIBIT, SDBCS_CMD_NOP: legal = 1'b1;
         SDBCS_CMD_ACTIVE: legal = (tgt == SDBCS_B_IDLE);
         SDBCS_CMD_READ, SDBCS_CMD_WRITE: begin
            legal = (tgt == SDBCS_B_ROW_ACTIVE) || (tgt == SDBCS_B_READ) || (tgt == SDBCS_B_WRITE);
         end
         SDBCS_CMD_PRECHARGE: begin
            if (dec.all_banks) begin
               legal = 1'b1;
               for (int i = 0; i < NUM_BANKS; i++) begin
                  if (bst[i] == SDBCS_B_ACTIVATING || bst[i] == SDBCS_B_READ_AP || bst[i] == SDBCS_B_WRITE_AP)
                     legal = 1'b0;
               end
            end else begin
               legal = (tgt != SDBCS_B_ACTIVATING) && (tgt != SDBCS_B_READ_AP) && (tgt != SDBCS_B_WRITE_AP);
            end
         end
         SDBCS_CMD_TERMINATE: legal = last_valid_ff;
         SDBCS_CMD_REFRESH, SDBCS_CMD_MODE_LOAD: legal = o_all_idle;
         default: legal = 1'b0;
      endcase
   end

   assign go = cmd_window && dev_free && legal && (dec.cmd != SDBCS_CMD_INHIBIT) && (dec.cmd != SDBCS_CMD_NOP);
   wire is_burst = go && (dec.cmd == SDBCS_CMD_READ || dec.cmd == SDBCS_CMD_WRITE);

   always_comb begin
      for (int i = 0; i < NUM_BANKS; i++) begin
         b_act[i] = go && (dec.cmd == SDBCS_CMD_ACTIVE) && (dec.bank == 2'(i));
         b_rd[i] = go && (dec.cmd == SDBCS_CMD_READ) && (dec.bank == 2'(i));
         b_wr[i] = go && (dec.cmd == SDBCS_CMD_WRITE) && (dec.bank == 2'(i));
         b_pre[i] = go && (dec.cmd == SDBCS_CMD_PRECHARGE) && !dec.all_banks && (dec.bank == 2'(i));
         b_stop[i] = go && (dec.cmd == SDBCS_CMD_TERMINATE) && (last_bank_ff == 2'(i));
         b_intr[i] = is_burst && (dec.bank != 2'(i));
      end
   end

   wire force_idle = (dev_ff != SDBCS_D_BANKS) && (dev_cnt_ff == '0);

   for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
      sdbcs_bank #(
         .TRP_CYC(TRP_CYC),
         .ACTIVATE_TO_ACCESS_TIME_CYC(ACTIVATE_TO_ACCESS_TIME_CYC),
         .BURST_LEN(BURST_LEN)
      ) u_bank (
         .i_clk_sys(i_clk_sys),
         .i_rstn(i_rstn),
         .i_act(b_act[g]),
         .i_rd(b_rd[g]),
         .i_wr(b_wr[g]),
         .i_auto_pre(dec.auto_pre),
         .i_pre(b_pre[g]),
         .i_stop(b_stop[g]),
         .i_interrupt(b_intr[g]),
         .i_force_idle(force_idle),
         .o_state(bst[g])
      );
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         cke_prev_ff <= 1'b0;
      end else begin
         cke_prev_ff <= i_cke;
      end
   end

   // exit time restarts on each self-refresh exit pulse
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         xsr_cnt_ff <= '0;
      end else if (i_self_refresh_exit) begin
         xsr_cnt_ff <= CW'(SELF_REFRESH_EXIT_TIME_CYC);
      end else if (xsr_cnt_ff != '0) begin
         xsr_cnt_ff <= xsr_cnt_ff - 1'b1;
      end
   end

   // device-wide states: refresh, mode load, precharge all
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         dev_ff <= SDBCS_D_BANKS;
         dev_cnt_ff <= '0;
      end else if (go && dec.cmd == SDBCS_CMD_REFRESH) begin
         dev_ff <= SDBCS_D_REFRESH;
         dev_cnt_ff <= CW'(REFRESH_CYCLE_TIME_CYC - 1);
      end else if (go && dec.cmd == SDBCS_CMD_MODE_LOAD) begin
         dev_ff <= SDBCS_D_MODE_LOAD;
         dev_cnt_ff <= CW'(MODE_LOAD_TIME_CYC - 1);
      end else if (go && dec.cmd == SDBCS_CMD_PRECHARGE && dec.all_banks) begin
         dev_ff <= SDBCS_D_PRE_ALL;
         dev_cnt_ff <= CW'(TRP_CYC - 1);
      end else if (force_idle) begin
         dev_ff <= SDBCS_D_BANKS;
      end else if (dev_cnt_ff != '0) begin
         dev_cnt_ff <= dev_cnt_ff - 1'b1;
      end
   end

   // most recent burst, for burst terminate
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         last_bank_ff <= 2'h0;
         last_valid_ff <= 1'b0;
      end else if (is_burst) begin
         last_bank_ff <= dec.bank;
         last_valid_ff <= 1'b1;
      end else if ((go && dec.cmd == SDBCS_CMD_TERMINATE) || force_idle) begin
         last_valid_ff <= 1'b0;
      end
   end

   // data bus owner: writes own it at once, reads after the read latency
   // one slot per latency cycle, so a later read never swallows an earlier one
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         rl_vld_ff <= '0;
         rl_bank_ff <= '0;
      end else if (go && dec.cmd == SDBCS_CMD_WRITE) begin
         rl_vld_ff <= '0; // write interrupts reads still in flight
      end else begin
         rl_vld_ff <= READ_LATENCY'({rl_vld_ff, go && (dec.cmd == SDBCS_CMD_READ)});
         rl_bank_ff <= BW'({rl_bank_ff, dec.bank});
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         data_bank_ff <= 2'h0;
         data_read_ff <= 1'b0;
         data_valid_ff <= 1'b0;
         data_cnt_ff <= '0;
      end else if (go && dec.cmd == SDBCS_CMD_WRITE) begin
         data_bank_ff <= dec.bank;
         data_read_ff <= 1'b0;
         data_valid_ff <= 1'b1;
         data_cnt_ff <= CW'(BURST_LEN - 1);
      end else if (rl_vld_ff[READ_LATENCY-1]) begin
         data_bank_ff <= rl_bank_ff[READ_LATENCY-1];
         data_read_ff <= 1'b1;
         data_valid_ff <= 1'b1;
         data_cnt_ff <= CW'(BURST_LEN - 1);
      end else if ((go && dec.cmd == SDBCS_CMD_TERMINATE) || (data_cnt_ff == '0)) begin
         data_valid_ff <= 1'b0;
      end else begin
         data_cnt_ff <= data_cnt_ff - 1'b1;
      end
   end

   // illegal commands flagged, never executed; limitation: banks simply ignore them
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_cmd_accepted <= 1'b0;
         o_cmd_illegal <= 1'b0;
      end else begin
         o_cmd_accepted <= go;
         o_cmd_illegal <= cmd_window && (dec.cmd != SDBCS_CMD_INHIBIT) && (dec.cmd != SDBCS_CMD_NOP)
            && !(dev_free && legal);
      end
   end

   assign o_bank_state = bst;
   assign o_dev_state = dev_ff;
   assign o_data_bank = data_bank_ff;
   assign o_data_read = data_read_ff;
   assign o_data_valid = data_valid_ff;
endmodule // sdbcs_top

// ---- testbench/sdbcs_checker.sv ----
// sdbcs_checker: timing and decode checks on the top ports
// assumes default timing parameters; bank 0 watched in detail
`timescale 1ns/1ps
module sdbcs_checker
   import sdbcs_pkg::*;
#(
   parameter int NUM_BANKS = 4
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // command pins
   input wire sdbcs_pins_t i_pins,
   input wire logic i_cke,
   // state view
   input wire sdbcs_bank_state_t [NUM_BANKS-1:0] o_bank_state,
   input wire sdbcs_dev_state_t o_dev_state,
   input wire logic o_all_idle,
   input wire logic o_cmd_accepted,
   input wire logic o_cmd_illegal,
   input wire logic [1:0] o_data_bank,
   input wire logic o_data_read,
   input wire logic o_data_valid
);
   logic [3:0] pin_cmd;
   logic sel0;
   sdbcs_bank_state_t b0;
   assign pin_cmd = {i_pins.cs_n, i_pins.ras_n, i_pins.cas_n, i_pins.we_n};
   assign sel0 = (i_pins.bank_select == 2'h0);
   assign b0 = o_bank_state[0];
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rstn);
   a_inhibit_quiet: assert property (i_pins.cs_n |=> !o_cmd_accepted && !o_cmd_illegal)
      else $error("inhibit answered");
   a_act_opens: assert property (pin_cmd == 4'h3 && sel0 && i_cke && $past(i_cke) && b0 == SDBCS_B_IDLE
      && o_dev_state == SDBCS_D_BANKS |=> b0 == SDBCS_B_ACTIVATING && o_cmd_accepted)
      else $error("activate not taken");
   a_act_len: assert property (b0 == SDBCS_B_ACTIVATING && $past(b0) != SDBCS_B_ACTIVATING
      |-> (b0 == SDBCS_B_ACTIVATING) [*2] ##1 b0 == SDBCS_B_ROW_ACTIVE)
      else $error("activate time wrong");
   a_pre_len: assert property (b0 == SDBCS_B_PRECHARGING && $past(b0) != SDBCS_B_PRECHARGING
      |-> (b0 == SDBCS_B_PRECHARGING) [*2] ##1 b0 == SDBCS_B_IDLE)
      else $error("precharge time wrong");
   a_pre_idle: assert property (pin_cmd == 4'h2 && !i_pins.addr[10] && sel0 && b0 == SDBCS_B_IDLE
      |=> b0 == SDBCS_B_IDLE)
      else $error("idle bank moved");
   a_rd_ap_busy: assert property (b0 == SDBCS_B_READ_AP && $past(b0) == SDBCS_B_ROW_ACTIVE
      |-> (b0 != SDBCS_B_IDLE) [*6] ##1 b0 == SDBCS_B_IDLE)
      else $error("auto precharge read length wrong");
   a_read_data: assert property (b0 == SDBCS_B_READ && $past(b0) == SDBCS_B_ROW_ACTIVE
      |-> ##3 o_data_valid && o_data_read && o_data_bank == 2'h0)
      else $error("read data late");
   a_refresh_len: assert property ($rose(o_dev_state == SDBCS_D_REFRESH)
      |-> (o_dev_state == SDBCS_D_REFRESH) [*7] ##1 o_dev_state == SDBCS_D_BANKS && o_all_idle)
      else $error("refresh length wrong");
   a_preall_len: assert property ($rose(o_dev_state == SDBCS_D_PRE_ALL)
      |-> (o_dev_state == SDBCS_D_PRE_ALL) [*2] ##1 o_dev_state == SDBCS_D_BANKS && o_all_idle)
      else $error("precharge all length wrong");
   a_cke_gate: assert property (!$past(i_cke) |=> !o_cmd_accepted)
      else $error("command taken without clock enable");
   c_refresh: cover property ($rose(o_dev_state == SDBCS_D_REFRESH));
   c_rd_ap: cover property (b0 == SDBCS_B_READ_AP);
   c_refused: cover property (o_cmd_illegal);
endmodule // sdbcs_checker

bind sdbcs_top sdbcs_checker #(.NUM_BANKS(NUM_BANKS)) u_chk (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
   .i_pins(i_pins), .i_cke(i_cke), .o_bank_state(o_bank_state), .o_dev_state(o_dev_state),
   .o_all_idle(o_all_idle), .o_cmd_accepted(o_cmd_accepted), .o_cmd_illegal(o_cmd_illegal),
   .o_data_bank(o_data_bank), .o_data_read(o_data_read), .o_data_valid(o_data_valid));

// ---- testbench/sdbcs_ctrl_model.sv ----
// sdbcs_ctrl_model: memory controller side, one command per clock
// assumes the bench calls issue just after a rising edge
`timescale 1ns/1ps
module sdbcs_ctrl_model
   import sdbcs_pkg::*;
(
   // clock
   input wire logic i_clk_sys,
   // command pins
   output sdbcs_pins_t o_pins
);
   // deselected until the first call
   initial o_pins = 18'h3c000;
   // address changes every call, so a stale row never looks valid
   task automatic issue(input logic [3:0] code, input logic [1:0] bank, input logic a10);
      logic [11:0] adr;
      adr = 12'($urandom);
      adr[10] = a10;
      o_pins <= {code, bank, adr};
      @(posedge i_clk_sys);
      #1;
   endtask
endmodule // sdbcs_ctrl_model

// ---- testbench/sdbcs_bench.sv ----
// sdbcs_bench: self-checking bench of the bank command state logic
// assumes default timing parameters and the controller model beside it
`timescale 1ns/1ps
module sdbcs_bench
   import sdbcs_pkg::*;
;
   localparam logic [3:0] C_NOP = 4'h7, C_ACT = 4'h3, C_RD = 4'h5, C_WR = 4'h4, C_PRE = 4'h2;
   localparam logic [3:0] C_TERM = 4'h6, C_REF = 4'h1, C_MRS = 4'h0, C_INH = 4'hd;
   localparam logic [1:0] NONE = 2'h0, ACC = 2'h1, ILL = 2'h2;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic cke = 1'b1;
   logic srx = 1'b0;
   sdbcs_pins_t pins;
   sdbcs_bank_state_t [3:0] bst;
   sdbcs_dev_state_t dst;
   logic all_idle, acc, ill, dread, dvalid;
   logic [1:0] dbank, bx;
   logic [1:0] exp_q[$];
   logic [3:0] op, op2;
   sdbcs_bank_state_t s1, s2;
   logic [3:0] dw_code [3] = '{C_PRE, C_REF, C_MRS};
   sdbcs_dev_state_t dw_st [3] = '{SDBCS_D_PRE_ALL, SDBCS_D_REFRESH, SDBCS_D_MODE_LOAD};
   int dw_len [3] = '{2, 7, 2};
   int err_total = 0;
   int n_checks = 0;
   always #5 clk = ~clk;
   sdbcs_ctrl_model ctl (.i_clk_sys(clk), .o_pins(pins));
   sdbcs_top dut (.i_clk_sys(clk), .i_rstn(rstn), .i_pins(pins), .i_cke(cke), .i_self_refresh_exit(srx),
      .o_bank_state(bst), .o_dev_state(dst), .o_all_idle(all_idle), .o_cmd_accepted(acc), .o_cmd_illegal(ill),
      .o_data_bank(dbank), .o_data_read(dread), .o_data_valid(dvalid));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      check("pending responses", 8'(exp_q.size()), 8'h00);
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // the expected answer is queued before the command leaves
   task automatic cmd(input logic [3:0] code, input logic [1:0] bank, input logic a10, input logic [1:0] res);
      if (res != NONE) exp_q.push_back(res);
      ctl.issue(code, bank, a10);
   endtask
   task automatic idle(input int n);
      repeat (n) ctl.issue(C_NOP, 2'h0, 1'b0);
   endtask
   task automatic chk_b(input logic [1:0] b, input sdbcs_bank_state_t s);
      check("bank state", {5'h0, bst[b]}, {5'h0, s});
   endtask
   // answers are registered, so sample away from the edge
   always @(negedge clk) begin
      if (rstn && (acc | ill) !== 1'b0) begin
         if (exp_q.size() == 0) check("response", {6'h0, ill, acc}, 8'h00);
         else check("response", {6'h0, ill, acc}, {6'h0, exp_q.pop_front()});
      end
   end
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      complete_run();
   end
   initial begin
      void'($urandom(32'h8be2));
      repeat (5) @(posedge clk);
      #1 rstn = 1'b1;
      idle(2);
      cmd(C_RD, 2'h0, 1'b0, ILL);
      chk_b(2'h0, SDBCS_B_IDLE);
      cmd(C_PRE, 2'h0, 1'b0, ACC);
      chk_b(2'h0, SDBCS_B_IDLE);
      cke = 1'b0;
      idle(1);
      cke = 1'b1;
      cmd(C_ACT, 2'h1, 1'b0, NONE);
      chk_b(2'h1, SDBCS_B_IDLE);
      for (int k = 0; k < 2; k++) begin
         op = k ? C_WR : C_RD;
         op2 = k ? C_RD : C_WR;
         s1 = k ? SDBCS_B_WRITE : SDBCS_B_READ;
         s2 = k ? SDBCS_B_READ : SDBCS_B_WRITE;
         cmd(C_ACT, 2'h0, 1'b0, ACC);
         chk_b(2'h0, SDBCS_B_ACTIVATING);
         cmd(C_ACT, 2'h0, 1'b0, ILL);
         chk_b(2'h0, SDBCS_B_ACTIVATING);
         idle(1);
         chk_b(2'h0, SDBCS_B_ROW_ACTIVE);
         cmd(op, 2'h0, 1'b0, ACC);
         cmd(C_INH, 2'h0, 1'b0, NONE);
         chk_b(2'h0, s1);
         cmd(op, 2'h0, 1'b0, ACC);
         idle(1);
         check("data owner", {4'h0, dvalid, dread, dbank}, k ? 8'h08 : 8'h0c);
         cmd(op2, 2'h0, 1'b0, ACC);
         chk_b(2'h0, s2);
         cmd(C_TERM, 2'h0, 1'b0, ACC);
         chk_b(2'h0, SDBCS_B_ROW_ACTIVE);
         cmd(C_WR, 2'h0, 1'b0, ACC);
         cmd(C_PRE, 2'h0, 1'b0, ACC);
         chk_b(2'h0, SDBCS_B_PRECHARGING);
         idle(1);
         chk_b(2'h0, SDBCS_B_PRECHARGING);
         idle(1);
         chk_b(2'h0, SDBCS_B_IDLE);
      end
      for (int k = 0; k < 2; k++) begin
         cmd(C_ACT, 2'h0, 1'b0, ACC);
         idle(2);
         cmd(k ? C_WR : C_RD, 2'h0, 1'b1, ACC);
         chk_b(2'h0, k ? SDBCS_B_WRITE_AP : SDBCS_B_READ_AP);
         cmd(C_RD, 2'h0, 1'b0, ILL);
         idle(4);
         check("bank busy", {7'h0, bst[0] == SDBCS_B_IDLE}, 8'h00);
         idle(1);
         chk_b(2'h0, SDBCS_B_IDLE);
      end
      bx = 2'($urandom_range(3, 1));
      cmd(C_ACT, bx, 1'b0, ACC);
      cmd(C_ACT, 2'h0, 1'b0, ACC);
      chk_b(bx, SDBCS_B_ACTIVATING);
      idle(2);
      cmd(C_RD, bx, 1'b1, ACC);
      cmd(C_RD, 2'h0, 1'b0, ACC);
      chk_b(bx, SDBCS_B_READ_AP);
      idle(2);
      check("data owner", {4'h0, dvalid, dread, dbank}, {6'h03, bx});
      idle(1);
      check("data owner", {4'h0, dvalid, dread, dbank}, 8'h0c);
      chk_b(bx, SDBCS_B_IDLE);
      // exit wait: commands ignored until the count runs out
      srx = 1'b1;
      idle(1);
      srx = 1'b0;
      idle(7);
      cmd(C_ACT, 2'h1, 1'b0, NONE);
      chk_b(2'h1, SDBCS_B_IDLE);
      cmd(C_ACT, 2'h1, 1'b0, ACC);
      chk_b(2'h1, SDBCS_B_ACTIVATING);
      idle(2);
      // precharge all first, while bank 0 still holds an open row
      for (int k = 0; k < 3; k++) begin
         cmd(dw_code[k], 2'h3, k == 0, ACC);
         check("device state", {6'h0, dst}, {6'h0, dw_st[k]});
         cmd(C_ACT, 2'h1, 1'b0, ILL);
         idle(dw_len[k] - 2);
         check("device state", {6'h0, dst}, {6'h0, dw_st[k]});
         idle(1);
         check("all idle", {5'h0, dst, all_idle}, 8'h01);
      end
      idle(2);
      complete_run();
   end
endmodule // sdbcs_bench
